// ==== inc/lnk_defines.svh ====
// Constants for the link transmit path and station address memory
`ifndef LNK_DEFINES_SVH
`define LNK_DEFINES_SVH

// Station address memory
`define LNK_ADDR_COUNT 12
`define LNK_ADDR_BITS 48
`define LNK_SAM_BASE 6'h10
`define LNK_WORD_USED_MSB 11

// Clock and bit timing, picoseconds
`define LNK_CLK_PS 8000
`define LNK_BIT_PS 100000
`define LNK_HALF_CYC (`LNK_BIT_PS / 2 / `LNK_CLK_PS)
`define LNK_SHAPE_MIN_PS 75000
`define LNK_SHAPE_MIN_CYC ((`LNK_SHAPE_MIN_PS + `LNK_CLK_PS - 1) / `LNK_CLK_PS)
`define LNK_CAR_IDLE_PS 150000
`define LNK_CAR_IDLE_CYC (`LNK_CAR_IDLE_PS / `LNK_CLK_PS)

// Carrier delay, nanoseconds
`define LNK_CAR_DELAY_NS 800
`define LNK_CAR_DELAY_CYC ((`LNK_CAR_DELAY_NS * 1000 + `LNK_CLK_PS - 1) / `LNK_CLK_PS)

// Interpacket gap, nanoseconds
`define LNK_IPG_NS 9600
`define LNK_IPG_CYC ((`LNK_IPG_NS * 1000 + `LNK_CLK_PS - 1) / `LNK_CLK_PS)

// Transmit buffer layout
`define LNK_TXB_STAT0 11'h000
`define LNK_TXB_COUNT 11'h001
`define LNK_TXB_FIRST 11'h002
`define LNK_TXB_LAST 11'h560
`define LNK_MAX_ATTEMPTS 5'h10

`endif

// ==== inc/lnk_pkg.sv ====
// Types for the link transmit path
package lnk_pkg;
  typedef logic [15:0] lnk_word_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_READ_CNT, TX_READ_DATA, TX_SEND, TX_WAIT_END, TX_WR_STAT0, TX_WR_STAT1
  } lnk_tx_state_t;
endpackage

// ==== verilog/lnk_sam.sv ====
// Bit-sliced station address memory
`timescale 1ns/1ps
`include "lnk_defines.svh"
module lnk_sam
  import lnk_pkg::*;
#(
  parameter int N_ADDR = `LNK_ADDR_COUNT,
  parameter int N_BITS = `LNK_ADDR_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Port write side
  input wire logic wr_en,
  input wire logic [5:0] wr_index,
  input wire lnk_word_t wr_data,
  // Receive state machine read side
  input wire logic [5:0] rd_index,
  output lnk_word_t rd_word
);
  initial begin
    if (N_ADDR < 1 || N_ADDR > 12 || N_BITS < 1 || N_BITS > 64) begin
      $error("lnk_sam: unsupported size");
    end
  end

  // R3: one column per address
  logic [N_ADDR-1:0] mem [0:N_BITS-1];

  // R18: reserved bits dropped on write
  always_ff @(posedge clk) begin
    if (wr_en && (int'(wr_index) < N_BITS)) begin
      mem[wr_index] <= wr_data[N_ADDR-1:0];
    end
  end

  // R18: reserved bits read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_word <= 16'h0000;
    end else begin
      rd_word <= 16'h0000;
      if (int'(rd_index) < N_BITS) begin
        rd_word[N_ADDR-1:0] <= mem[rd_index];
      end
    end
  end
endmodule

// ==== verilog/lnk_phy_top.sv ====
// Link physical channel, station address memory and transmit buffer sequencing
`timescale 1ns/1ps
`include "lnk_defines.svh"
// Overview of operation
// R1: Twelve 48-bit station addresses stored
// R2: Write only with enable bit and strobe
// R3: Word n holds bit n of each
// R4: First memory word at select 20 octal
// R5: Carrier on while any station transmits
// R6: Carrier delayed by 800 ns
// R7: Delayed and undelayed carrier fan out
// R8: Collision flagged for any two transmitters
// R9: Collision squelch ORed with receive squelch
// R10: Collision double-synchronised to system clock
// R11: Collision alerts transmit and retry logic
// R12: Decoder yields data and recovered clock
// R13: Encoder merges clock and shifter bit
// R14: Transmit only after slot and gap
// R15: Word 0 ignored, word 1 byte count
// R16: Data words 2-1376, odd low byte last
// R17: Status written on success or 16 failures
// R18: Reserved address memory bits read zero
module lnk_phy_top
  import lnk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command register and link memory bus
  input wire logic station_address_memory_enable,
  input wire logic command_write_strobe,
  input wire logic [5:0] address_memory_select,
  input wire lnk_word_t lm_rdata,
  input wire logic lm_rvalid,
  output logic [10:0] lm_addr,
  output logic lm_rd,
  output logic lm_wr,
  output lnk_word_t lm_wdata,
  // Receive state machine address read
  input wire logic [5:0] sam_rd_index,
  output lnk_word_t address_bit_slice_word,
  // Transceiver pins
  input wire logic rx_line,
  input wire logic collision_in,
  output logic tx_line,
  output logic tx_drive,
  // Receive path
  output logic carrier_raw,
  output logic carrier_delayed,
  output logic rx_clk_en,
  output logic rx_data,
  output logic collision_detect,
  output logic retry_alert,
  // Transmit control
  input wire logic tx_request,
  input wire logic slot_time_expired,
  input wire logic jam_request,
  input wire logic tx_go,
  input wire logic frame_done,
  input wire logic attempt_failed,
  input wire lnk_word_t tx_stat0,
  input wire lnk_word_t tx_stat1,
  output logic tx_permit,
  output logic tx_busy
);
  localparam int HALF_CYC = `LNK_HALF_CYC;
  localparam int SHAPE_CYC = `LNK_SHAPE_MIN_CYC;
  localparam int IDLE_CYC = `LNK_CAR_IDLE_CYC;
  localparam int DLY_CYC = `LNK_CAR_DELAY_CYC;
  localparam int IPG_CYC = `LNK_IPG_CYC;

  initial begin
    if (HALF_CYC < 2 || SHAPE_CYC >= 2 * HALF_CYC || DLY_CYC < 2) begin
      $error("lnk_phy_top: clock too slow for bit timing");
    end
  end

  // Pin synchronisers
  logic rx_m;
  logic rx_s;
  logic rx_prev;
  logic col_m;
  logic col_s;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Idle line is high, so no false edge after reset
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_m <= rx_line;
      rx_s <= rx_m;
      rx_prev <= rx_s;
    end
  end

  // R10: two-stage collision synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      col_m <= 1'b0;
      col_s <= 1'b0;
    end else begin
      col_m <= collision_in;
      col_s <= col_m;
    end
  end

  // Station address memory write path
  logic sam_wr;
  logic [5:0] sam_index;

  // R4: select counts from octal 20
  assign sam_index = address_memory_select - `LNK_SAM_BASE;
  // R2: enable bit and strobe both needed
  assign sam_wr = station_address_memory_enable && command_write_strobe && (address_memory_select >= `LNK_SAM_BASE);

  // R1: twelve 48-bit addresses
  lnk_sam #(
    .N_ADDR(`LNK_ADDR_COUNT),
    .N_BITS(`LNK_ADDR_BITS)
  ) u_sam (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(sam_wr),
    .wr_index(sam_index),
    .wr_data(lm_rdata),
    .rd_index(sam_rd_index),
    .rd_word(address_bit_slice_word)
  );

  // Manchester decoder and clock shaper
  logic [7:0] since_edge;
  logic [7:0] since_mid;
  logic rx_edge;

  assign rx_edge = rx_s ^ rx_prev;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_edge <= 8'hff;
    end else if (rx_edge) begin
      since_edge <= 8'h00;
    end else if (since_edge != 8'hff) begin
      since_edge <= since_edge + 8'h01;
    end
  end

  // R12: mid-bit edges give data and clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_mid <= 8'hff;
      rx_clk_en <= 1'b0;
      rx_data <= 1'b0;
    end else begin
      rx_clk_en <= 1'b0;
      if (since_mid != 8'hff) begin
        since_mid <= since_mid + 8'h01;
      end
      // Shaper ignores edges too soon after the last clock
      if (rx_edge && since_mid >= 8'(SHAPE_CYC)) begin
        since_mid <= 8'h00;
        rx_clk_en <= 1'b1;
        rx_data <= rx_s;
      end
    end
  end

  // Carrier sense and delay
  logic rx_squelch;
  logic [DLY_CYC-2:0] car_dly;

  assign rx_squelch = rx_edge || (since_edge < 8'(IDLE_CYC));

  // R5: on while line transitions continue
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      carrier_raw <= 1'b0;
    end else begin
      // R9: collision squelch ORed in
      carrier_raw <= rx_squelch | col_s;
    end
  end

  // R6: 800 ns delay line
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      car_dly <= '0;
      carrier_delayed <= 1'b0;
    end else begin
      car_dly <= {car_dly[DLY_CYC-3:0], carrier_raw};
      // R7: delayed copy for receive side
      carrier_delayed <= car_dly[DLY_CYC-2];
    end
  end

  // R8: collision indication
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      collision_detect <= 1'b0;
      retry_alert <= 1'b0;
    end else begin
      collision_detect <= col_s;
      // R11: one pulse per collision onset
      retry_alert <= col_s & ~collision_detect;
    end
  end

  // Interpacket gap counter on undelayed carrier
  logic [11:0] ipg_cnt;
  logic ipg_done;

  assign ipg_done = ipg_cnt == 12'(IPG_CYC);

  // R7: undelayed carrier times the gap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ipg_cnt <= 12'(IPG_CYC);
    end else if (carrier_raw) begin
      ipg_cnt <= 12'h000;
    end else if (!ipg_done) begin
      ipg_cnt <= ipg_cnt + 12'h001;
    end
  end

  // R14: slot and gap gate transmit enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_permit <= 1'b0;
    end else begin
      tx_permit <= jam_request | (tx_request & slot_time_expired & ipg_done);
    end
  end

  // Half-bit timing for the encoder
  logic [4:0] half_cnt;
  logic half_en;
  logic phase;
  logic bit_start;

  assign half_en = half_cnt == 5'(HALF_CYC - 1);
  assign bit_start = half_en & ~phase;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_cnt <= 5'h00;
      phase <= 1'b0;
    end else if (half_en) begin
      half_cnt <= 5'h00;
      phase <= ~phase;
    end else begin
      half_cnt <= half_cnt + 5'h01;
    end
  end

  // Transmit buffer sequencer
  lnk_tx_state_t state;
  logic [11:0] tx_byte_count;
  logic [15:0] word;
  logic [7:0] shreg;
  logic [2:0] bit_idx;
  logic hi_byte;
  logic [4:0] attempts;
  logic cur_bit;
  logic jam_bit;

  // Memory must answer within half a bit time or tx_drive drops until it does
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= TX_IDLE;
      lm_addr <= 11'h000;
      lm_rd <= 1'b0;
      lm_wr <= 1'b0;
      lm_wdata <= 16'h0000;
      tx_byte_count <= 12'h000;
      word <= 16'h0000;
      shreg <= 8'h00;
      bit_idx <= 3'h0;
      hi_byte <= 1'b0;
      attempts <= 5'h00;
      cur_bit <= 1'b0;
      tx_busy <= 1'b0;
    end else begin
      lm_rd <= 1'b0;
      lm_wr <= 1'b0;
      tx_busy <= state != TX_IDLE;
      case (state)
        TX_IDLE: begin
          if (tx_go) begin
            // R15: word 0 skipped, count from word 1
            lm_addr <= `LNK_TXB_COUNT;
            lm_rd <= 1'b1;
            state <= TX_READ_CNT;
          end
        end
        TX_READ_CNT: begin
          if (lm_rvalid) begin
            // R15: byte count in bits 11 to 0
            tx_byte_count <= lm_rdata[11:0];
            lm_addr <= `LNK_TXB_FIRST;
            lm_rd <= lm_rdata[11:0] != 12'h000;
            state <= (lm_rdata[11:0] != 12'h000) ? TX_READ_DATA : TX_WAIT_END;
          end
        end
        TX_READ_DATA: begin
          if (lm_rvalid) begin
            word <= lm_rdata;
            // R16: low byte goes first, so an odd tail is the low byte
            shreg <= lm_rdata[7:0];
            hi_byte <= 1'b0;
            bit_idx <= 3'h0;
            state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (bit_start) begin
            cur_bit <= shreg[0];
            shreg <= {1'b0, shreg[7:1]};
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
              tx_byte_count <= tx_byte_count - 12'h001;
              if (tx_byte_count == 12'h001) begin
                state <= TX_WAIT_END;
              end else if (!hi_byte) begin
                shreg <= word[15:8];
                hi_byte <= 1'b1;
              end else if (lm_addr != `LNK_TXB_LAST) begin
                // R16: data words end at 1376
                lm_addr <= lm_addr + 11'h001;
                lm_rd <= 1'b1;
                state <= TX_READ_DATA;
              end else begin
                state <= TX_WAIT_END;
              end
            end
          end
        end
        TX_WAIT_END: begin
          if (frame_done) begin
            state <= TX_WR_STAT0;
          end
        end
        TX_WR_STAT0: begin
          lm_addr <= `LNK_TXB_STAT0;
          lm_wdata <= tx_stat0;
          lm_wr <= 1'b1;
          state <= TX_WR_STAT1;
        end
        TX_WR_STAT1: begin
          lm_addr <= `LNK_TXB_COUNT;
          lm_wdata <= tx_stat1;
          lm_wr <= 1'b1;
          attempts <= 5'h00;
          state <= TX_IDLE;
        end
        default: begin
          state <= TX_IDLE;
        end
      endcase
      // R17: status after sixteen failed attempts
      if (attempt_failed && state != TX_WR_STAT0 && state != TX_WR_STAT1 && state != TX_IDLE) begin
        attempts <= attempts + 5'h01;
        state <= (attempts + 5'h01 == `LNK_MAX_ATTEMPTS) ? TX_WR_STAT0 : TX_IDLE;
      end
    end
  end

  // Jam pattern alternates per bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      jam_bit <= 1'b0;
    end else if (bit_start) begin
      jam_bit <= ~jam_bit;
    end
  end

  // R13: Manchester encoder, inverted then true half
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_line <= 1'b0;
      tx_drive <= 1'b0;
    end else if (half_en) begin
      tx_drive <= jam_request | (state == TX_SEND);
      if (jam_request) begin
        tx_line <= phase ? ~jam_bit : jam_bit;
      end else if (state == TX_SEND) begin
        tx_line <= phase ? cur_bit : ~cur_bit;
      end else begin
        tx_line <= 1'b0;
      end
    end
  end
endmodule

// ==== test/lnk_lm_model.sv ====
// Link memory model that answers transmit buffer reads
`timescale 1ns/1ps
module lnk_lm_model
  import lnk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Buffer read side
  input wire logic [10:0] lm_addr,
  input wire logic lm_rd,
  input wire logic [2:0] lat,
  output lnk_word_t mem_rdata,
  output logic lm_rvalid
);
  lnk_word_t mem [0:2047];
  logic [2:0] cnt;
  logic [10:0] ra;
  logic busy;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      lm_rvalid <= 1'b0;
      mem_rdata <= 16'h5a5a;
    end else begin
      lm_rvalid <= 1'b0;
      if (lm_rd) begin
        busy <= 1'b1;
        ra <= lm_addr;
        cnt <= lat;
      end else if (busy && cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else if (busy) begin
        busy <= 1'b0;
        lm_rvalid <= 1'b1;
        mem_rdata <= mem[ra];
      end else begin
        // Released bus toggles, never holds
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule

// ==== test/lnk_phy_top_asserts.sv ====
// Port checks for the link physical channel top
`timescale 1ns/1ps
module lnk_phy_top_asserts
  import lnk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Address memory
  input wire logic station_address_memory_enable,
  input wire logic command_write_strobe,
  input wire logic [5:0] address_memory_select,
  input wire lnk_word_t lm_rdata,
  input wire logic [5:0] sam_rd_index,
  input wire lnk_word_t address_bit_slice_word,
  // Channel
  input wire logic rx_line,
  input wire logic collision_in,
  input wire logic carrier_raw,
  input wire logic carrier_delayed,
  input wire logic collision_detect,
  input wire logic retry_alert,
  // Transmit
  input wire logic tx_request,
  input wire logic slot_time_expired,
  input wire logic jam_request,
  input wire logic tx_permit,
  input wire logic tx_go,
  input wire logic tx_busy,
  input wire logic lm_rd,
  input wire logic lm_wr,
  input wire logic [10:0] lm_addr
);
  logic sam_wr_q;
  logic [5:0] sam_idx_q;
  logic [11:0] sam_dat_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sam_wr_q <= 1'b0;
    end else begin
      sam_wr_q <= station_address_memory_enable && command_write_strobe && address_memory_select >= 6'h10;
    end
  end
  always_ff @(posedge clk) begin
    sam_idx_q <= address_memory_select - 6'h10;
    sam_dat_q <= lm_rdata[11:0];
  end
  a_sam_readback: assert property (sam_wr_q && !command_write_strobe && sam_rd_index == sam_idx_q
    |=> address_bit_slice_word == {4'h0, $past(sam_dat_q)}) else $error("stored word differs");
  a_sam_reserved: assert property (address_bit_slice_word[15:12] == 4'h0)
    else $error("reserved bits set");
  a_car_rise: assert property ($rose(carrier_raw) |-> ##100 carrier_delayed)
    else $error("delayed carrier late");
  a_car_fall: assert property ($fell(carrier_raw) |-> ##100 !carrier_delayed)
    else $error("delayed carrier stuck");
  a_car_follow: assert property ($changed(rx_line) |-> ##[1:6] carrier_raw)
    else $error("no carrier on data");
  a_coll_carrier: assert property (collision_detect |-> carrier_raw)
    else $error("collision without carrier");
  a_coll_sync: assert property ($rose(collision_in) ##1 collision_in [*2] |=> collision_detect)
    else $error("collision not synced");
  a_retry_onset: assert property ($rose(collision_detect) |-> retry_alert ##1 !retry_alert)
    else $error("retry pulse wrong");
  a_permit_jam: assert property (jam_request |=> tx_permit)
    else $error("jam without permit");
  a_permit_hold: assert property (!jam_request && !(tx_request && slot_time_expired) |=> !tx_permit)
    else $error("permit without cause");
  a_count_first: assert property (tx_go && !tx_busy && !$past(tx_go) |=> lm_rd && lm_addr == 11'h001)
    else $error("count word not read");
  a_addr_range: assert property (lm_rd |-> lm_addr >= 11'h001 && lm_addr <= 11'h560)
    else $error("read outside buffer");
  a_stat_pair: assert property (lm_wr && lm_addr == 11'h000 |=> lm_wr && lm_addr == 11'h001 ##1 !lm_wr)
    else $error("status pair broken");
  c_delayed: cover property ($rose(carrier_delayed));
  c_retry: cover property (retry_alert);
  c_status: cover property (lm_wr && lm_addr == 11'h001);
endmodule
bind lnk_phy_top lnk_phy_top_asserts u_lnk_phy_top_asserts (.*);

// ==== test/lnk_phy_top_tb_top.sv ====
// Self-checking bench for the link physical channel top
`timescale 1ns/1ps
module lnk_phy_top_tb_top;
  import lnk_pkg::*;
  logic clk = 0, sys_rst = 1, station_address_memory_enable = 0, command_write_strobe = 0, rx_line = 1, collision_in = 0;
  logic tx_request = 0, slot_time_expired = 0, jam_request = 0, tx_go = 0, frame_done = 0, attempt_failed = 0;
  logic [5:0] address_memory_select = 0, sam_rd_index = 0;
  lnk_word_t sam_data = 0, tx_stat0 = 0, tx_stat1 = 0, lm_rdata, mem_rdata, lm_wdata, address_bit_slice_word;
  logic lm_rvalid, lm_rd, lm_wr, tx_line, tx_drive, carrier_raw, carrier_delayed, rx_clk_en, rx_data;
  logic collision_detect, retry_alert, tx_permit, tx_busy, sam_chk = 0, sam_d = 0, link_ck = 0;
  logic [2:0] lat = 1;
  logic [10:0] lm_addr;
  logic [31:0] seed = 32'h0eab_5a83;
  int miscompares = 0, check_count = 0;
  lnk_word_t sam_q[$], rx_q[$], rd_q[$], wr_q[$], shadow[48];
  // Shared data lines: address memory data only while enabled
  assign lm_rdata = station_address_memory_enable ? sam_data : mem_rdata;
  lnk_phy_top u_lnk_phy_top (.*);
  lnk_lm_model u_lnk_lm_model (.*);
  always #4 clk = ~clk;
  function automatic lnk_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return lnk_word_t'(seed);
  endfunction
  function automatic lnk_word_t pop(ref lnk_word_t q[$]);
    return q.size() ? q.pop_front() : 16'hxxxx;
  endfunction
  task automatic check(input lnk_word_t seen, input lnk_word_t exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && tx_busy !== 1'b0; i++) cyc(1);
    if (i == 3000) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic pulse_go();
    tx_go = 1;
    cyc(1);
    tx_go = 0;
  endtask
  always @(posedge clk) begin
    sam_d <= sam_chk;
    if (sam_d) check(address_bit_slice_word, pop(sam_q));
    if (rx_clk_en) begin
      check(rx_data, pop(rx_q));
      check(carrier_raw, 16'h0001);
    end
    if (lm_rd) check(lm_addr, pop(rd_q));
    if (lm_wr) begin
      check(lm_addr, pop(wr_q));
      check(lm_wdata, pop(wr_q));
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    cyc(12);
    sys_rst = 0;
    station_address_memory_enable = 1;
    command_write_strobe = 1;
    for (int n = 0; n < 48; n++) begin
      shadow[n] = rnd();
      address_memory_select = 6'(n + 16);
      sam_data = shadow[n];
      cyc(1);
    end
    // Refused: strobe without enable, then select below base
    station_address_memory_enable = 0;
    address_memory_select = 6'h15;
    cyc(1);
    station_address_memory_enable = 1;
    address_memory_select = 6'h0f;
    sam_data = rnd();
    cyc(1);
    command_write_strobe = 0;
    for (int n = 0; n < 48; n++) begin
      sam_rd_index = 6'(n);
      sam_chk = 1;
      sam_q.push_back(shadow[n] & 16'h0fff);
      cyc(1);
    end
    sam_chk = 0;
    command_write_strobe = 1;
    address_memory_select = 6'h12;
    sam_data = rnd();
    cyc(1);
    command_write_strobe = 0;
    sam_rd_index = 6'h02;
    sam_chk = 1;
    sam_q.push_back(sam_data & 16'h0fff);
    cyc(1);
    sam_chk = 0;
    station_address_memory_enable = 0;
    tx_request = 1;
    slot_time_expired = 1;
    cyc(3);
    check(tx_permit, 16'h0001);
    #3.3;
    for (int b = 0; b < 16; b++) begin
      rx_q.push_back(lnk_word_t'(b[0]));
      rx_line = ~b[0];
      link_ck = 1;
      #80;
      rx_line = b[0];
      link_ck = 0;
      #80;
    end
    cyc(30);
    check(tx_permit, 16'h0000);
    cyc(600);
    check(tx_permit, 16'h0000);
    cyc(700);
    check(tx_permit, 16'h0001);
    tx_request = 0;
    jam_request = 1;
    collision_in = 1;
    cyc(5);
    check(tx_permit, 16'h0001);
    check(collision_detect, 16'h0001);
    check(carrier_raw, 16'h0001);
    jam_request = 0;
    collision_in = 0;
    cyc(30);
    tx_stat0 = rnd();
    tx_stat1 = rnd();
    lat = 3'(rnd() % 7);
    u_lnk_lm_model.mem[1] = 16'h0003;
    u_lnk_lm_model.mem[2] = rnd();
    u_lnk_lm_model.mem[3] = rnd();
    rd_q = '{16'h0001, 16'h0002, 16'h0003};
    pulse_go();
    cyc(40);
    check(tx_drive, 16'h0001);
    pulse_go();
    cyc(400);
    wr_q = '{16'h0000, tx_stat0, 16'h0001, tx_stat1};
    frame_done = 1;
    cyc(1);
    frame_done = 0;
    wait_idle();
    u_lnk_lm_model.mem[1] = 16'h0000;
    attempt_failed = 1;
    cyc(1);
    attempt_failed = 0;
    for (int a = 1; a <= 16; a++) begin
      lat = 3'(rnd() % 7);
      rd_q.push_back(16'h0001);
      if (a == 16) wr_q = '{16'h0000, tx_stat0, 16'h0001, tx_stat1};
      pulse_go();
      cyc(20);
      attempt_failed = 1;
      cyc(1);
      attempt_failed = 0;
      wait_idle();
    end
    cyc(5);
    check(16'(sam_q.size() + rx_q.size() + rd_q.size() + wr_q.size()), 16'h0000);
    stop_test();
  end
endmodule
